// file: logic/dubhp_defs.svh
// Operation
// R1: address lines pick the selected channel's register
// R2: eight-bit shared data bus, driven only on reads
// R3: read strobe fall reads register, drives bus
// R4: host captures read byte at strobe rise
// R5: write strobe rise loads bus byte into register
// R6: channel answers only while its select low
// R7: modem bit three set: irq driven, gp low
// R8: modem bit three clear: irq floats, gp high
// R9: active-low tx ready shows holding register state
// R10: active-low rx ready shows holding register state
// R11: each channel has its own irq pin
// R12: no select: strobes ignored, bus released
`ifndef DUBHP_DEFS_SVH
`define DUBHP_DEFS_SVH

// ==========================================
// widths
`define DUBHP_DATA_W      8
`define DUBHP_ADDR_W      3
`define DUBHP_NUM_REGS    8
`define DUBHP_NUM_CHAN    2

// ==========================================
// register indices inside one channel
`define DUBHP_REG_HOLD    3'h0
`define DUBHP_REG_IRQ_EN  3'h1
`define DUBHP_REG_MODEM   3'h4
`define DUBHP_REG_LINE    3'h5

// ==========================================
// field positions
`define DUBHP_MODEM_IRQ_BIT 3
`define DUBHP_IEN_RX_BIT    0
`define DUBHP_IEN_TX_BIT    1
`define DUBHP_LINE_RX_BIT   0
`define DUBHP_LINE_TX_BIT   5

// ==========================================
// reset values
`define DUBHP_REG_RST     8'h00
`define DUBHP_DOUT_RST    8'h00

// ==========================================
// pin synchroniser vector: data, addr, rd, wr, sel a, sel b
`define DUBHP_PIN_W       15
`define DUBHP_PIN_RST     15'h7800
`define DUBHP_PIN_ADDR_LO 8
`define DUBHP_PIN_RD      11
`define DUBHP_PIN_WR      12
`define DUBHP_PIN_SEL_A   13
`define DUBHP_PIN_SEL_B   14

`endif

// file: logic/dubhp_pkg.sv
package dubhp_pkg;

  // ==========================================
  // access sequencer states
  typedef enum logic [1:0] {
    DUBHP_IDLE  = 2'b00,
    DUBHP_READ  = 2'b01,
    DUBHP_WRITE = 2'b10
  } dubhp_state_t;

  // ==========================================
  // channel being served
  typedef enum logic {
    DUBHP_CHAN_A = 1'b0,
    DUBHP_CHAN_B = 1'b1
  } dubhp_chan_t;

endpackage

// file: logic/dubhp_chan.sv
`timescale 1ns/1ps
`include "dubhp_defs.svh"
module dubhp_chan import dubhp_pkg::*; (
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  input  wire logic [`DUBHP_ADDR_W-1:0]   addr_in,
  input  wire logic [`DUBHP_DATA_W-1:0]   wdata_in,
  output logic      [`DUBHP_DATA_W-1:0]   rdata_out,
  input  wire logic                       rx_load_in,
  input  wire logic [`DUBHP_DATA_W-1:0]   rx_byte_in,
  input  wire logic                       tx_take_in,
  output logic      [`DUBHP_DATA_W-1:0]   tx_byte_out,
  output logic                            tx_ready_n_out,
  output logic                            rx_ready_n_out,
  output logic                            irq_out,
  output logic                            irq_oe_n_out,
  output logic                            gp_out_two_n_out
);

  // ==========================================
  // state
  logic [`DUBHP_DATA_W-1:0] regs      [`DUBHP_NUM_REGS];
  logic [`DUBHP_DATA_W-1:0] next_regs [`DUBHP_NUM_REGS];
  logic [`DUBHP_DATA_W-1:0] rx_hold;
  logic [`DUBHP_DATA_W-1:0] next_rx_hold;
  logic                     tx_full;
  logic                     next_tx_full;
  logic                     rx_full;
  logic                     next_rx_full;
  logic                     next_irq;
  logic                     next_irq_oe_n;
  logic                     next_gp;
  logic                     pending;
  logic                     irq_on;

  assign tx_byte_out = regs[`DUBHP_REG_HOLD];

  // ==========================================
  // next values; hardware sets win over clears in the same cycle
  always_comb begin
    next_regs    = regs;
    next_rx_hold = rx_hold;
    next_tx_full = tx_full;
    next_rx_full = rx_full;
    if (tx_take_in) begin
      next_tx_full = 1'b0;
    end
    if (rd_in && addr_in == `DUBHP_REG_HOLD) begin
      next_rx_full = 1'b0;
    end
    if (wr_in) begin // R5
      if (addr_in == `DUBHP_REG_HOLD) begin
        next_regs[`DUBHP_REG_HOLD] = wdata_in;
        next_tx_full               = 1'b1;
      end else if (addr_in != `DUBHP_REG_LINE) begin
        next_regs[addr_in] = wdata_in; // R1
      end
    end
    if (rx_load_in) begin
      next_rx_hold = rx_byte_in;
      next_rx_full = 1'b1;
    end
    irq_on  = next_regs[`DUBHP_REG_MODEM][`DUBHP_MODEM_IRQ_BIT];
    pending = (next_rx_full & next_regs[`DUBHP_REG_IRQ_EN][`DUBHP_IEN_RX_BIT])
            | (~next_tx_full & next_regs[`DUBHP_REG_IRQ_EN][`DUBHP_IEN_TX_BIT]);
    next_irq      = irq_on & pending; // R7
    next_irq_oe_n = ~irq_on;          // R8
    next_gp       = ~irq_on;          // R7 R8
  end

  // ==========================================
  // read mux, sampled by the port at the read start
  always_comb begin
    rdata_out = regs[addr_in]; // R1
    if (addr_in == `DUBHP_REG_HOLD) begin
      rdata_out = rx_hold;
    end else if (addr_in == `DUBHP_REG_LINE) begin
      rdata_out                     = `DUBHP_REG_RST;
      rdata_out[`DUBHP_LINE_RX_BIT] = rx_full;
      rdata_out[`DUBHP_LINE_TX_BIT] = ~tx_full;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `DUBHP_NUM_REGS; i++) begin
        regs[i] <= `DUBHP_REG_RST;
      end
      rx_hold          <= `DUBHP_REG_RST;
      tx_full          <= 1'b0;
      rx_full          <= 1'b0;
      irq_out          <= 1'b0;
      irq_oe_n_out     <= 1'b1;
      gp_out_two_n_out <= 1'b1;
      tx_ready_n_out   <= 1'b0;
      rx_ready_n_out   <= 1'b1;
    end else begin
      regs             <= next_regs;
      rx_hold          <= next_rx_hold;
      tx_full          <= next_tx_full;
      rx_full          <= next_rx_full;
      irq_out          <= next_irq;
      irq_oe_n_out     <= next_irq_oe_n;
      gp_out_two_n_out <= next_gp;
      tx_ready_n_out   <= next_tx_full;  // R9
      rx_ready_n_out   <= ~next_rx_full; // R10
    end
  end

endmodule

// file: logic/dubhp_host_port.sv
`timescale 1ns/1ps
`include "dubhp_defs.svh"
module dubhp_host_port import dubhp_pkg::*; #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic                       CLK_IN,
  input  wire logic                       RST_N_IN,
  input  wire logic [`DUBHP_ADDR_W-1:0]   ADDR_IN,
  input  wire logic [`DUBHP_DATA_W-1:0]   DATA_IN,
  output logic      [`DUBHP_DATA_W-1:0]   DATA_OUT,
  output logic                            DATA_OE_N_OUT,
  input  wire logic                       READ_STROBE_N_IN,
  input  wire logic                       WRITE_STROBE_N_IN,
  input  wire logic                       CHAN_A_SELECT_N_IN,
  input  wire logic                       CHAN_B_SELECT_N_IN,
  output logic                            CHAN_A_IRQ_OUT,
  output logic                            CHAN_A_IRQ_OE_N_OUT,
  output logic                            CHAN_B_IRQ_OUT,
  output logic                            CHAN_B_IRQ_OE_N_OUT,
  output logic                            CHAN_A_GP_OUT_TWO_N_OUT,
  output logic                            CHAN_B_GP_OUT_TWO_N_OUT,
  output logic                            CHAN_A_TX_READY_N_OUT,
  output logic                            CHAN_B_TX_READY_N_OUT,
  output logic                            CHAN_A_RX_READY_N_OUT,
  output logic                            CHAN_B_RX_READY_N_OUT,
  input  wire logic                       CHAN_A_RX_LOAD_IN,
  input  wire logic [`DUBHP_DATA_W-1:0]   CHAN_A_RX_BYTE_IN,
  input  wire logic                       CHAN_B_RX_LOAD_IN,
  input  wire logic [`DUBHP_DATA_W-1:0]   CHAN_B_RX_BYTE_IN,
  input  wire logic                       CHAN_A_TX_TAKE_IN,
  input  wire logic                       CHAN_B_TX_TAKE_IN,
  output logic      [`DUBHP_DATA_W-1:0]   CHAN_A_TX_BYTE_OUT,
  output logic      [`DUBHP_DATA_W-1:0]   CHAN_B_TX_BYTE_OUT
);

  // ==========================================
  // elaboration checks
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least two");
  end

  // ==========================================
  // pin synchroniser
  // the whole bus moves through the same stages, so address and data
  // stay aligned with the strobes that qualify them
  logic [`DUBHP_PIN_W-1:0] pin_sync      [SYNC_STAGES];
  logic [`DUBHP_PIN_W-1:0] next_pin_sync [SYNC_STAGES];
  logic [`DUBHP_PIN_W-1:0] pins_raw;
  logic [`DUBHP_PIN_W-1:0] pins;

  assign pins_raw = {CHAN_B_SELECT_N_IN, CHAN_A_SELECT_N_IN,
                     WRITE_STROBE_N_IN, READ_STROBE_N_IN, ADDR_IN, DATA_IN};
  assign pins     = pin_sync[SYNC_STAGES-1];

  always_comb begin
    next_pin_sync[0] = pins_raw;
    for (int s = 1; s < SYNC_STAGES; s++) begin
      next_pin_sync[s] = pin_sync[s-1];
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int s = 0; s < SYNC_STAGES; s++) begin
        pin_sync[s] <= `DUBHP_PIN_RST;
      end
    end else begin
      pin_sync <= next_pin_sync;
    end
  end

  // ==========================================
  // synchronised pin fields
  logic                     rd_n;
  logic                     wr_n;
  logic                     sel_a;
  logic                     sel_b;
  logic [`DUBHP_ADDR_W-1:0] s_addr;
  logic [`DUBHP_DATA_W-1:0] s_data;

  assign rd_n   = pins[`DUBHP_PIN_RD];
  assign wr_n   = pins[`DUBHP_PIN_WR];
  assign sel_a  = ~pins[`DUBHP_PIN_SEL_A];
  assign sel_b  = ~pins[`DUBHP_PIN_SEL_B];
  assign s_addr = pins[`DUBHP_PIN_ADDR_LO +: `DUBHP_ADDR_W];
  assign s_data = pins[`DUBHP_DATA_W-1:0];

  // ==========================================
  // strobe edge detect on the synchronised copies
  logic rd_n_d;
  logic wr_n_d;
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;

  assign rd_fall = rd_n_d & ~rd_n;
  assign rd_rise = ~rd_n_d & rd_n;
  assign wr_fall = wr_n_d & ~wr_n;
  assign wr_rise = ~wr_n_d & wr_n;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rd_n_d <= 1'b1;
      wr_n_d <= 1'b1;
    end else begin
      rd_n_d <= rd_n;
      wr_n_d <= wr_n;
    end
  end

  // ==========================================
  // access sequencer
  dubhp_state_t             state;
  dubhp_state_t             next_state;
  dubhp_chan_t              chan;
  dubhp_chan_t              next_chan;
  logic [`DUBHP_ADDR_W-1:0] addr;
  logic [`DUBHP_ADDR_W-1:0] next_addr;
  logic [`DUBHP_DATA_W-1:0] next_dout;
  logic                     next_oe_n;
  logic                     any_sel;
  logic                     chan_sel;
  logic                     pick_b;
  logic [`DUBHP_NUM_CHAN-1:0] ch_rd;
  logic [`DUBHP_NUM_CHAN-1:0] ch_wr;
  logic [`DUBHP_ADDR_W-1:0] ch_addr;
  logic [`DUBHP_DATA_W-1:0] ch_rdata [`DUBHP_NUM_CHAN];

  assign any_sel  = sel_a | sel_b;
  // both selects low is a host fault; channel a wins
  assign pick_b   = ~sel_a;
  assign chan_sel = (chan == DUBHP_CHAN_A) ? sel_a : sel_b;

  always_comb begin
    next_state = state;
    next_chan  = chan;
    next_addr  = addr;
    next_dout  = DATA_OUT;
    next_oe_n  = DATA_OE_N_OUT;
    ch_rd      = '0;
    ch_wr      = '0;
    ch_addr    = addr;
    unique case (state)
      DUBHP_IDLE: begin
        next_oe_n = 1'b1; // R12
        if (any_sel && rd_fall) begin // R6
          next_chan  = pick_b ? DUBHP_CHAN_B : DUBHP_CHAN_A;
          next_addr  = s_addr; // R1
          ch_addr    = s_addr;
          ch_rd[pick_b] = 1'b1; // R3
          next_dout  = ch_rdata[pick_b];
          next_oe_n  = 1'b0; // R2
          next_state = DUBHP_READ;
        end else if (any_sel && wr_fall) begin // R5
          next_chan  = pick_b ? DUBHP_CHAN_B : DUBHP_CHAN_A;
          next_addr  = s_addr; // R1
          next_state = DUBHP_WRITE;
        end
      end
      DUBHP_READ: begin
        // host samples at its own rising edge, byte stays until then
        if (rd_rise || !chan_sel) begin // R4 R6
          next_oe_n  = 1'b1; // R2
          next_state = DUBHP_IDLE;
        end
      end
      DUBHP_WRITE: begin
        if (!chan_sel) begin // R6
          next_state = DUBHP_IDLE;
        end else if (wr_rise) begin // R5
          ch_wr[chan] = 1'b1;
          next_state  = DUBHP_IDLE;
        end
      end
      default: begin
        next_oe_n  = 1'b1;
        next_state = DUBHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state         <= DUBHP_IDLE;
      chan          <= DUBHP_CHAN_A;
      addr          <= '0;
      DATA_OUT      <= `DUBHP_DOUT_RST;
      DATA_OE_N_OUT <= 1'b1;
    end else begin
      state         <= next_state;
      chan          <= next_chan;
      addr          <= next_addr;
      DATA_OUT      <= next_dout;
      DATA_OE_N_OUT <= next_oe_n;
    end
  end

  // ==========================================
  // channels
  logic                     rx_load    [`DUBHP_NUM_CHAN];
  logic [`DUBHP_DATA_W-1:0] rx_byte    [`DUBHP_NUM_CHAN];
  logic                     tx_take    [`DUBHP_NUM_CHAN];
  logic [`DUBHP_DATA_W-1:0] tx_byte    [`DUBHP_NUM_CHAN];
  logic                     tx_ready_n [`DUBHP_NUM_CHAN];
  logic                     rx_ready_n [`DUBHP_NUM_CHAN];
  logic                     irq        [`DUBHP_NUM_CHAN];
  logic                     irq_oe_n   [`DUBHP_NUM_CHAN];
  logic                     gp_two_n   [`DUBHP_NUM_CHAN];

  assign rx_load[0] = CHAN_A_RX_LOAD_IN;
  assign rx_load[1] = CHAN_B_RX_LOAD_IN;
  assign rx_byte[0] = CHAN_A_RX_BYTE_IN;
  assign rx_byte[1] = CHAN_B_RX_BYTE_IN;
  assign tx_take[0] = CHAN_A_TX_TAKE_IN;
  assign tx_take[1] = CHAN_B_TX_TAKE_IN;

  for (genvar c = 0; c < `DUBHP_NUM_CHAN; c++) begin : g_chan
    dubhp_chan u_chan (
      .clk_in           (CLK_IN),
      .rst_n_in         (RST_N_IN),
      .wr_in            (ch_wr[c]),
      .rd_in            (ch_rd[c]),
      .addr_in          (ch_addr),
      .wdata_in         (s_data),
      .rdata_out        (ch_rdata[c]),
      .rx_load_in       (rx_load[c]),
      .rx_byte_in       (rx_byte[c]),
      .tx_take_in       (tx_take[c]),
      .tx_byte_out      (tx_byte[c]),
      .tx_ready_n_out   (tx_ready_n[c]),
      .rx_ready_n_out   (rx_ready_n[c]),
      .irq_out          (irq[c]),
      .irq_oe_n_out     (irq_oe_n[c]),
      .gp_out_two_n_out (gp_two_n[c])
    );
  end

  // ==========================================
  // per-channel pins, each straight from a channel flop
  assign CHAN_A_IRQ_OUT          = irq[0];      // R11
  assign CHAN_A_IRQ_OE_N_OUT     = irq_oe_n[0];
  assign CHAN_B_IRQ_OUT          = irq[1];      // R11
  assign CHAN_B_IRQ_OE_N_OUT     = irq_oe_n[1];
  assign CHAN_A_GP_OUT_TWO_N_OUT = gp_two_n[0];
  assign CHAN_B_GP_OUT_TWO_N_OUT = gp_two_n[1];
  assign CHAN_A_TX_READY_N_OUT   = tx_ready_n[0];
  assign CHAN_B_TX_READY_N_OUT   = tx_ready_n[1];
  assign CHAN_A_RX_READY_N_OUT   = rx_ready_n[0];
  assign CHAN_B_RX_READY_N_OUT   = rx_ready_n[1];
  assign CHAN_A_TX_BYTE_OUT      = tx_byte[0];
  assign CHAN_B_TX_BYTE_OUT      = tx_byte[1];

endmodule

// file: verification/dubhp_host_port_asserts.sv
`timescale 1ns/1ps
`include "dubhp_defs.svh"
// ====
// bus port checks
module dubhp_host_port_asserts #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic                     CLK_IN,
  input wire logic                     RST_N_IN,
  input wire logic [`DUBHP_ADDR_W-1:0] ADDR_IN,
  input wire logic                     READ_STROBE_N_IN,
  input wire logic                     WRITE_STROBE_N_IN,
  input wire logic                     CHAN_A_SELECT_N_IN,
  input wire logic                     CHAN_B_SELECT_N_IN,
  input wire logic                     DATA_OE_N_OUT,
  input wire logic                     CHAN_A_IRQ_OUT,
  input wire logic                     CHAN_A_IRQ_OE_N_OUT,
  input wire logic                     CHAN_B_IRQ_OUT,
  input wire logic                     CHAN_B_IRQ_OE_N_OUT,
  input wire logic                     CHAN_A_GP_OUT_TWO_N_OUT,
  input wire logic                     CHAN_A_TX_READY_N_OUT,
  input wire logic                     CHAN_B_TX_READY_N_OUT,
  input wire logic                     CHAN_A_RX_READY_N_OUT,
  input wire logic                     CHAN_A_RX_LOAD_IN,
  input wire logic                     CHAN_B_TX_TAKE_IN
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  property p_read_drive;
    $fell(READ_STROBE_N_IN) && !(CHAN_A_SELECT_N_IN && CHAN_B_SELECT_N_IN)
      |-> ##[1:4] !DATA_OE_N_OUT;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read strobe did not drive the bus");
  // five samples cover the synchroniser plus the output register
  property p_idle_release;
    READ_STROBE_N_IN [*5] |-> DATA_OE_N_OUT;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("bus driven without a read");
  property p_nosel;
    (CHAN_A_SELECT_N_IN && CHAN_B_SELECT_N_IN) [*5] |-> DATA_OE_N_OUT;
  endproperty
  a_nosel: assert property (p_nosel)
    else $error("bus driven with no channel selected");
  property p_gp_a;
    CHAN_A_IRQ_OE_N_OUT == CHAN_A_GP_OUT_TWO_N_OUT;
  endproperty
  a_gp_a: assert property (p_gp_a)
    else $error("gp output disagrees with irq enable");
  property p_float_a;
    CHAN_A_IRQ_OE_N_OUT |-> !CHAN_A_IRQ_OUT;
  endproperty
  a_float_a: assert property (p_float_a)
    else $error("channel a irq high while floating");
  property p_float_b;
    CHAN_B_IRQ_OE_N_OUT |-> !CHAN_B_IRQ_OUT;
  endproperty
  a_float_b: assert property (p_float_b)
    else $error("channel b irq high while floating");
  property p_tx_full;
    $rose(WRITE_STROBE_N_IN) && !CHAN_A_SELECT_N_IN && ADDR_IN == 3'h0
      |-> ##[3:6] CHAN_A_TX_READY_N_OUT;
  endproperty
  a_tx_full: assert property (p_tx_full)
    else $error("holding write did not clear tx ready");
  property p_rx_load;
    CHAN_A_RX_LOAD_IN |=> !CHAN_A_RX_READY_N_OUT;
  endproperty
  a_rx_load: assert property (p_rx_load)
    else $error("rx load did not raise rx ready");
  property p_tx_take;
    CHAN_B_TX_TAKE_IN |=> !CHAN_B_TX_READY_N_OUT;
  endproperty
  a_tx_take: assert property (p_tx_take)
    else $error("tx take did not restore tx ready");
endmodule

// file: verification/dubhp_host_model.sv
`timescale 1ns/1ps
// ====
// host processor on the asynchronous byte bus
module dubhp_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] dout_in,
  input  wire logic       oe_n_in,
  output logic      [7:0] data_out,
  output logic      [2:0] addr_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic      [1:0] sel_n_out
);
  logic       drive = 1'b0;
  logic [7:0] wbyte = 8'h00;
  logic [7:0] last  = 8'h00;
  // a released bus has no pull: show a changing pattern, not the old byte
  assign data_out = drive ? wbyte : (!oe_n_in ? dout_in : ~last);
  always @(posedge clk_in) last <= data_out;
  initial begin
    addr_out = 3'h0;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    sel_n_out = 2'b11;
  end
  task automatic access(input logic [1:0] sel_n, input logic wr, input logic [2:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
    int n;
    @(negedge clk_in);
    sel_n_out = sel_n;
    addr_out = addr;
    drive = wr;
    wbyte = wdata;
    @(negedge clk_in);
    if (wr) wr_n_out = 1'b0;
    else rd_n_out = 1'b0;
    n = 0;
    while (!wr && oe_n_in !== 1'b0 && n < 8) begin
      @(negedge clk_in);
      n++;
    end
    repeat (4) @(negedge clk_in);
    rdata = data_out;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    // hold address, select and data past the rise for the synchroniser
    repeat (4) @(negedge clk_in);
    sel_n_out = 2'b11;
    drive = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask
endmodule

// file: verification/dubhp_host_port_tb.sv
`timescale 1ns/1ps
`include "dubhp_defs.svh"
module dubhp_host_port_tb;
  typedef struct packed {
    logic       chan;
    logic [2:0] addr;
    logic [7:0] val;
  } dubhp_row_t;
  logic       clk, rst_n, oe_n, rd_n, wr_n, irq_a, irq_oe_a, irq_b, irq_oe_b, gp_a, gp_b;
  logic       txr_a, txr_b, rxr_a, rxr_b, rxl_a, rxl_b, take_a, take_b;
  logic [1:0] sel_n;
  logic [2:0] addr;
  logic [7:0] din, dout, rxb_a, rxb_b, txb_a, txb_b, rd;
  int         failures, compares;
  // ====
  // plain storage rows
  dubhp_row_t rows [8] = '{'{1'b0, 3'h2, 8'h11}, '{1'b0, 3'h3, 8'h22}, '{1'b0, 3'h6, 8'h33},
    '{1'b0, 3'h7, 8'h44}, '{1'b1, 3'h2, 8'h55}, '{1'b1, 3'h3, 8'h66},
    '{1'b1, 3'h6, 8'h77}, '{1'b1, 3'h7, 8'h88}};

  dubhp_host_port #(.SYNC_STAGES(2)) dubhp_host_port_inst (
    .CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_OE_N_OUT(oe_n), .READ_STROBE_N_IN(rd_n), .WRITE_STROBE_N_IN(wr_n),
    .CHAN_A_SELECT_N_IN(sel_n[0]), .CHAN_B_SELECT_N_IN(sel_n[1]),
    .CHAN_A_IRQ_OUT(irq_a), .CHAN_A_IRQ_OE_N_OUT(irq_oe_a), .CHAN_B_IRQ_OUT(irq_b),
    .CHAN_B_IRQ_OE_N_OUT(irq_oe_b), .CHAN_A_GP_OUT_TWO_N_OUT(gp_a),
    .CHAN_B_GP_OUT_TWO_N_OUT(gp_b), .CHAN_A_TX_READY_N_OUT(txr_a),
    .CHAN_B_TX_READY_N_OUT(txr_b), .CHAN_A_RX_READY_N_OUT(rxr_a),
    .CHAN_B_RX_READY_N_OUT(rxr_b), .CHAN_A_RX_LOAD_IN(rxl_a), .CHAN_A_RX_BYTE_IN(rxb_a),
    .CHAN_B_RX_LOAD_IN(rxl_b), .CHAN_B_RX_BYTE_IN(rxb_b), .CHAN_A_TX_TAKE_IN(take_a),
    .CHAN_B_TX_TAKE_IN(take_b), .CHAN_A_TX_BYTE_OUT(txb_a), .CHAN_B_TX_BYTE_OUT(txb_b));
  dubhp_host_model dubhp_host_model_inst (.clk_in(clk), .dout_in(dout), .oe_n_in(oe_n),
    .data_out(din), .addr_out(addr), .rd_n_out(rd_n), .wr_n_out(wr_n), .sel_n_out(sel_n));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic c, input logic [2:0] a, input logic [7:0] v);
    dubhp_host_model_inst.access({~c, c}, 1'b1, a, v, rd);
  endtask
  task automatic rreg(input logic c, input logic [2:0] a);
    dubhp_host_model_inst.access({~c, c}, 1'b0, a, 8'h00, rd);
  endtask
  // a whole run is 34 accesses of 12 to 15 cycles
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    end_of_test;
  end
  initial begin
    rst_n = 1'b0;
    {rxl_a, rxl_b, take_a, take_b} = 4'h0;
    rxb_a = 8'h00;
    rxb_b = 8'h00;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk("data oe", oe_n, 8'h01);
    chk("irq oe a", irq_oe_a, 8'h01);
    chk("gp b", gp_b, 8'h01);
    chk("tx ready a", txr_a, 8'h00);
    chk("rx ready b", rxr_b, 8'h01);
    foreach (rows[i]) wreg(rows[i].chan, rows[i].addr, rows[i].val);
    foreach (rows[i]) begin
      rreg(rows[i].chan, rows[i].addr);
      chk("plain reg", rd, rows[i].val);
    end
    dubhp_host_model_inst.access(2'b11, 1'b1, 3'h2, 8'hEE, rd);
    rreg(1'b0, 3'h2);
    chk("unselected write", rd, 8'h11);
    // both selects low is a host fault: only channel a may take the byte
    dubhp_host_model_inst.access(2'b00, 1'b1, 3'h2, 8'hA5, rd);
    rreg(1'b0, 3'h2);
    chk("both selected a", rd, 8'hA5);
    rreg(1'b1, 3'h2);
    chk("both selected b", rd, 8'h55);
    wreg(1'b0, 3'h0, 8'h5A);
    chk("tx ready a", txr_a, 8'h01);
    chk("tx byte a", txb_a, 8'h5A);
    chk("tx ready b", txr_b, 8'h00);
    {take_a, take_b} = 2'h3;
    @(negedge clk);
    {take_a, take_b} = 2'h0;
    chk("tx ready a", txr_a, 8'h00);
    {rxl_a, rxl_b, rxb_a, rxb_b} = {2'h3, 8'h3C, 8'hC3};
    @(negedge clk);
    {rxl_a, rxl_b} = 2'h0;
    chk("rx ready b", rxr_b, 8'h00);
    rreg(1'b1, 3'h0);
    chk("rx byte b", rd, 8'hC3);
    chk("rx ready b", rxr_b, 8'h01);
    chk("rx ready a", rxr_a, 8'h00);
    // the status index is read-only
    wreg(1'b0, 3'h5, 8'hFF);
    rreg(1'b0, 3'h5);
    chk("line status a", rd, 8'h21);
    rreg(1'b0, 3'h0);
    chk("rx byte a", rd, 8'h3C);
    chk("rx ready a", rxr_a, 8'h01);
    wreg(1'b0, 3'h1, 8'h02);
    wreg(1'b0, 3'h4, 8'h08);
    chk("irq oe a", irq_oe_a, 8'h00);
    chk("gp a", gp_a, 8'h00);
    chk("irq a", irq_a, 8'h01);
    chk("irq oe b", irq_oe_b, 8'h01);
    wreg(1'b0, 3'h0, 8'h55);
    chk("irq a", irq_a, 8'h00);
    wreg(1'b0, 3'h4, 8'h00);
    chk("irq oe a", irq_oe_a, 8'h01);
    chk("gp a", gp_a, 8'h01);
    wreg(1'b1, 3'h1, 8'h01);
    wreg(1'b1, 3'h4, 8'h08);
    chk("gp b", gp_b, 8'h00);
    chk("irq oe b", irq_oe_b, 8'h00);
    chk("irq b", irq_b, 8'h00);
    {rxl_b, rxb_b} = {1'b1, 8'h99};
    @(negedge clk);
    rxl_b = 1'b0;
    repeat (3) @(negedge clk);
    chk("irq b", irq_b, 8'h01);
    chk("irq a", irq_a, 8'h00);
    wreg(1'b1, 3'h0, 8'hB6);
    chk("tx byte b", txb_b, 8'hB6);
    chk("tx ready b", txr_b, 8'h01);
    // reset in mid-run must bring every channel b pin back to its idle level
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("tx byte b", txb_b, 8'h00);
    chk("tx ready b", txr_b, 8'h00);
    chk("rx ready b", rxr_b, 8'h01);
    chk("irq b", irq_b, 8'h00);
    chk("irq oe b", irq_oe_b, 8'h01);
    chk("gp b", gp_b, 8'h01);
    rst_n = 1'b1;
    rreg(1'b1, 3'h2);
    chk("plain reg after reset", rd, 8'h00);
    end_of_test;
  end
endmodule

bind dubhp_host_port dubhp_host_port_asserts #(.SYNC_STAGES(SYNC_STAGES))
  dubhp_host_port_asserts_inst (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN),
  .READ_STROBE_N_IN(READ_STROBE_N_IN), .WRITE_STROBE_N_IN(WRITE_STROBE_N_IN),
  .CHAN_A_SELECT_N_IN(CHAN_A_SELECT_N_IN), .CHAN_B_SELECT_N_IN(CHAN_B_SELECT_N_IN),
  .DATA_OE_N_OUT(DATA_OE_N_OUT), .CHAN_A_IRQ_OUT(CHAN_A_IRQ_OUT),
  .CHAN_A_IRQ_OE_N_OUT(CHAN_A_IRQ_OE_N_OUT), .CHAN_B_IRQ_OUT(CHAN_B_IRQ_OUT),
  .CHAN_B_IRQ_OE_N_OUT(CHAN_B_IRQ_OE_N_OUT), .CHAN_A_GP_OUT_TWO_N_OUT(CHAN_A_GP_OUT_TWO_N_OUT),
  .CHAN_A_TX_READY_N_OUT(CHAN_A_TX_READY_N_OUT), .CHAN_B_TX_READY_N_OUT(CHAN_B_TX_READY_N_OUT),
  .CHAN_A_RX_READY_N_OUT(CHAN_A_RX_READY_N_OUT), .CHAN_A_RX_LOAD_IN(CHAN_A_RX_LOAD_IN),
  .CHAN_B_TX_TAKE_IN(CHAN_B_TX_TAKE_IN));
